// File: hdl/lrr_light_regs.sv
// Result and configuration registers of an ambient light sensor behind an I2C target.
// Assumes scl and sda arrive from pins; the light level input comes from same-clock logic.
`default_nettype none

module lrr_light_regs #(
  parameter int SHORT_CYC = lrr_pkg::CONV_SHORT_CYC,
  parameter int LONG_CYC  = lrr_pkg::CONV_LONG_CYC
) (
  input  wire logic                     clk,       // 20 MHz clock
  input  wire logic                     nrst,      // Async reset, active low
  input  wire logic                     sclIn,     // Serial clock pin
  input  wire logic                     sdaIn,     // Serial data pin level
  output logic                          sdaOut,    // Serial data drive value
  output logic                          sdaOe,     // Serial data drive enable
  input  wire logic [lrr_pkg::RAW_W-1:0] lightRaw, // Light level, 0.01 lux units
  output logic                          convBusy   // Conversion running
);

  // ----------------------------------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------------------------------
  logic [1:0] sclSync_ff, sdaSync_ff;
  logic       sclPrev_ff, sdaPrev_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclSync_ff <= 2'b11;
      sdaSync_ff <= 2'b11;
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else begin
      sclSync_ff <= {sclSync_ff[0], sclIn};
      sdaSync_ff <= {sdaSync_ff[0], sdaIn};
      sclPrev_ff <= sclSync_ff[1];
      sdaPrev_ff <= sdaSync_ff[1];
    end
  end
  wire logic scl     = sclSync_ff[1];
  wire logic sda     = sdaSync_ff[1];
  wire logic sclRise = scl & ~sclPrev_ff;
  wire logic sclFall = ~scl & sclPrev_ff;
  wire logic busStart = scl & sclPrev_ff & sdaPrev_ff & ~sda;
  wire logic busStop  = scl & sclPrev_ff & ~sdaPrev_ff & sda;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0]  rangeSelect_ff;
  logic        convTimeSel_ff;
  logic [1:0]  convMode_ff;
  logic [lrr_pkg::CFG_LOW_W-1:0] cfgLow_ff;  // Latch, polarity, mask, fault count
  logic        overflowFlag_ff, convReadyFlag_ff;
  logic [3:0]  resExp_ff;
  logic [11:0] resMant_ff;
  logic        convActive_ff;
  logic [23:0] timer_ff;
  logic        cfgWr;
  logic [15:0] cfgWrData;

  wire logic exponentMaskEn = cfgLow_ff[2];
  wire logic autoRange      = (rangeSelect_ff == lrr_pkg::RANGE_AUTO);
  wire logic manualRange    = (rangeSelect_ff < lrr_pkg::RANGE_AUTO);

  // ----------------------------------------------------------------
  // Range selection and conversion result
  // ----------------------------------------------------------------
  function automatic logic [3:0] pick_range(input logic [lrr_pkg::RAW_W-1:0] raw);
    logic [3:0] e;
    e = lrr_pkg::RANGE_MAX;
    for (int i = int'(lrr_pkg::RANGE_MAX); i >= 0; i--) begin
      if ((raw >> i) <= lrr_pkg::RAW_W'(lrr_pkg::MANT_FULL)) begin
        e = 4'(i);
      end
    end
    return e;
  endfunction

  wire logic [3:0] autoExp  = pick_range(lightRaw);                            // R10
  wire logic [3:0] convExp  = autoRange ? autoExp : rangeSelect_ff;            // R11
  wire logic [lrr_pkg::RAW_W-1:0] scaled = lightRaw >> convExp;                // R4
  wire logic convOvf = (scaled > lrr_pkg::RAW_W'(lrr_pkg::MANT_FULL));
  wire logic [11:0] convMant = convOvf ? lrr_pkg::MANT_FULL : scaled[11:0];    // R3

  wire logic [23:0] convTarget = convTimeSel_ff ? 24'(LONG_CYC - 1) : 24'(SHORT_CYC - 1);
  wire logic convDone  = convActive_ff & (timer_ff == convTarget) & ~cfgWr;
  wire logic [1:0] newMode = cfgWrData[lrr_pkg::CFG_MODE_LSB +: 2];
  wire logic wantConv  = (newMode != lrr_pkg::MODE_SHUTDOWN);                  // R13
  wire logic singleEnd = convDone & (convMode_ff == lrr_pkg::MODE_SINGLE);     // R13

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      convActive_ff <= 1'b0;
      timer_ff      <= 24'h000000;
    end else if (cfgWr) begin
      convActive_ff <= wantConv;                                               // R6 R7
      timer_ff      <= 24'h000000;
    end else if (convDone) begin
      convActive_ff <= ~singleEnd;
      timer_ff      <= 24'h000000;
    end else if (convActive_ff) begin
      timer_ff      <= timer_ff + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resExp_ff       <= 4'h0;
      resMant_ff      <= 12'h000;
      overflowFlag_ff <= 1'b0;
    end else if (convDone) begin
      resExp_ff       <= convExp;                                              // R2
      resMant_ff      <= convMant;
      overflowFlag_ff <= convOvf;
    end
  end

  // Set on completion; a configuration write clears it, even in a conversion's last cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      convReadyFlag_ff <= 1'b0;
    end else if (convDone) begin
      convReadyFlag_ff <= 1'b1;
    end else if (cfgWr) begin
      convReadyFlag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rangeSelect_ff <= lrr_pkg::CFG_RESET[lrr_pkg::CFG_RN_LSB +: 4];          // R9
      convTimeSel_ff <= lrr_pkg::CFG_RESET[lrr_pkg::CFG_CT_BIT];
      convMode_ff    <= lrr_pkg::CFG_RESET[lrr_pkg::CFG_MODE_LSB +: 2];
      cfgLow_ff      <= lrr_pkg::CFG_RESET[lrr_pkg::CFG_LOW_W-1:0];
    end else if (cfgWr) begin
      rangeSelect_ff <= cfgWrData[lrr_pkg::CFG_RN_LSB +: 4];                   // R8
      convTimeSel_ff <= cfgWrData[lrr_pkg::CFG_CT_BIT];
      convMode_ff    <= newMode;
      cfgLow_ff      <= cfgWrData[lrr_pkg::CFG_LOW_W-1:0];                     // R15
    end else if (singleEnd) begin
      convMode_ff    <= lrr_pkg::MODE_SHUTDOWN;
    end
  end

  // ----------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------
  wire logic [3:0] shownExp = (exponentMaskEn & manualRange) ? 4'h0 : resExp_ff; // R5
  wire logic [15:0] resultWord = {shownExp, resMant_ff};                       // R1
  wire logic [15:0] configWord = {rangeSelect_ff, convTimeSel_ff, convMode_ff,
                                  overflowFlag_ff, convReadyFlag_ff, 2'b00, cfgLow_ff}; // R8
  logic [7:0] regPtr_ff;
  wire logic [15:0] readWord = (regPtr_ff == lrr_pkg::REG_RESULT) ? resultWord :
                               (regPtr_ff == lrr_pkg::REG_CONFIG) ? configWord : 16'h0000;

  // ----------------------------------------------------------------
  // I2C target
  // ----------------------------------------------------------------
  lrr_pkg::lrr_state_t state_ff;
  logic [7:0]  rxShift_ff;
  logic [2:0]  bitCnt_ff;
  logic        byteDone_ff, readDir_ff, txLsb_ff, sdaOe_ff;
  logic [1:0]  wrIdx_ff;
  logic [7:0]  wrMsb_ff;
  logic [15:0] txWord_ff;
  logic [7:0]  txShift_ff;
  wire logic [7:0] rxByte = rxShift_ff;

  assign cfgWr     = (state_ff == lrr_pkg::ST_RX) & sclFall & byteDone_ff &
                     (wrIdx_ff == 2'd2) & (regPtr_ff == lrr_pkg::REG_CONFIG);
  assign cfgWrData = {wrMsb_ff, rxByte};                                       // R14
  assign sdaOut    = 1'b0;
  assign sdaOe     = sdaOe_ff;
  assign convBusy  = convActive_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff    <= lrr_pkg::ST_IDLE;
      rxShift_ff  <= 8'h00;
      bitCnt_ff   <= 3'h0;
      byteDone_ff <= 1'b0;
      readDir_ff  <= 1'b0;
      txLsb_ff    <= 1'b0;
      sdaOe_ff    <= 1'b0;
      wrIdx_ff    <= 2'd0;
      wrMsb_ff    <= 8'h00;
      regPtr_ff   <= 8'h00;
      txWord_ff   <= 16'h0000;
      txShift_ff  <= 8'h00;
    end else if (busStart) begin
      state_ff    <= lrr_pkg::ST_ADDR;
      bitCnt_ff   <= 3'h0;
      byteDone_ff <= 1'b0;
      sdaOe_ff    <= 1'b0;
    end else if (busStop) begin
      state_ff    <= lrr_pkg::ST_IDLE;
      sdaOe_ff    <= 1'b0;
    end else begin
      unique case (state_ff)
        lrr_pkg::ST_IDLE: begin
          sdaOe_ff <= 1'b0;
        end
        lrr_pkg::ST_ADDR, lrr_pkg::ST_RX: begin
          if (sclRise) begin
            rxShift_ff  <= {rxShift_ff[6:0], sda};
            bitCnt_ff   <= bitCnt_ff + 3'h1;
            byteDone_ff <= (bitCnt_ff == 3'h7);
          end else if (sclFall && byteDone_ff) begin
            byteDone_ff <= 1'b0;
            if (state_ff == lrr_pkg::ST_ADDR) begin
              if (rxByte[7:1] == lrr_pkg::DEV_ADDR) begin
                state_ff   <= lrr_pkg::ST_ADRACK;
                readDir_ff <= rxByte[0];
                sdaOe_ff   <= 1'b1;
              end else begin
                state_ff <= lrr_pkg::ST_IDLE;
              end
            end else begin
              state_ff <= lrr_pkg::ST_RXACK;
              sdaOe_ff <= 1'b1;
              if (wrIdx_ff == 2'd0) begin
                regPtr_ff <= rxByte;
              end
              if (wrIdx_ff == 2'd1) begin
                wrMsb_ff <= rxByte;                                            // R14
              end
              wrIdx_ff <= (wrIdx_ff == 2'd2) ? 2'd1 : wrIdx_ff + 2'd1;
            end
          end
        end
        lrr_pkg::ST_ADRACK: begin
          if (sclFall) begin
            bitCnt_ff <= 3'h0;
            if (readDir_ff) begin
              state_ff   <= lrr_pkg::ST_TX;
              txWord_ff  <= readWord;
              txShift_ff <= readWord[15:8];                                    // R14
              sdaOe_ff   <= ~readWord[15];
              txLsb_ff   <= 1'b0;
            end else begin
              state_ff <= lrr_pkg::ST_RX;
              sdaOe_ff <= 1'b0;
              wrIdx_ff <= 2'd0;
            end
          end
        end
        lrr_pkg::ST_RXACK: begin
          if (sclFall) begin
            state_ff  <= lrr_pkg::ST_RX;
            sdaOe_ff  <= 1'b0;
            bitCnt_ff <= 3'h0;
          end
        end
        lrr_pkg::ST_TX: begin
          if (sclFall) begin
            if (bitCnt_ff == 3'h7) begin
              state_ff <= lrr_pkg::ST_TXACK;
              sdaOe_ff <= 1'b0;
            end else begin
              bitCnt_ff  <= bitCnt_ff + 3'h1;
              txShift_ff <= {txShift_ff[6:0], 1'b0};
              sdaOe_ff   <= ~txShift_ff[6];
            end
          end
        end
        lrr_pkg::ST_TXACK: begin
          if (sclRise && sda) begin
            state_ff <= lrr_pkg::ST_IDLE;
          end else if (sclFall) begin
            state_ff   <= lrr_pkg::ST_TX;
            bitCnt_ff  <= 3'h0;
            txLsb_ff   <= ~txLsb_ff;
            txShift_ff <= txLsb_ff ? txWord_ff[15:8] : txWord_ff[7:0];        // R14
            sdaOe_ff   <= txLsb_ff ? ~txWord_ff[15] : ~txWord_ff[7];
          end
        end
        default: begin
          state_ff <= lrr_pkg::ST_IDLE;
          sdaOe_ff <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_exp_range;
    @(posedge clk) disable iff (!nrst) resExp_ff <= lrr_pkg::RANGE_MAX;
  endproperty
  a_exp_range: assert property (p_exp_range) else $error("exponent above 11"); // R4

  property p_mask;
    @(posedge clk) disable iff (!nrst)
      (regPtr_ff == lrr_pkg::REG_RESULT && exponentMaskEn && manualRange)
        |-> (readWord[15:12] == 4'h0 && readWord[11:0] == resMant_ff);
  endproperty
  a_mask: assert property (p_mask) else $error("masked exponent not zero"); // R5

  property p_abort;
    @(posedge clk) disable iff (!nrst) cfgWr |=> (timer_ff == 24'h000000);
  endproperty
  a_abort: assert property (p_abort) else $error("write did not abort"); // R6

  property p_restart;
    @(posedge clk) disable iff (!nrst) (cfgWr && wantConv) |=> convActive_ff ##1 convActive_ff;
  endproperty
  a_restart: assert property (p_restart) else $error("no new conversion"); // R7

  property p_shutdown;
    @(posedge clk) disable iff (!nrst) (cfgWr && !wantConv) |=> !convActive_ff;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown still converting"); // R13

  property p_result;
    @(posedge clk) disable iff (!nrst)
      convDone |=> (resMant_ff == $past(convMant) && overflowFlag_ff == $past(convOvf));
  endproperty
  a_result: assert property (p_result) else $error("result not updated"); // R2

  property p_auto;
    @(posedge clk) disable iff (!nrst) (convDone && autoRange) |=> resExp_ff == $past(autoExp);
  endproperty
  a_auto: assert property (p_auto) else $error("auto range not reported"); // R10

  property p_manual;
    @(posedge clk) disable iff (!nrst)
      (convDone && manualRange) |=> resExp_ff == $past(rangeSelect_ff);
  endproperty
  a_manual: assert property (p_manual) else $error("manual range not used"); // R11

  property p_ro_bits;
    @(posedge clk) disable iff (!nrst)
      (cfgWr && !convDone) |=> ($stable(overflowFlag_ff) && !convReadyFlag_ff
                                && configWord[6:5] == 2'b00);
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("read-only bit written"); // R15

endmodule

`default_nettype wire

// File: pkg/lrr_pkg.sv
// Constants, field layout and state codes for the light result and range register block.
// Assumes a 20 MHz system clock and an I2C target front end in the same clock domain.
//
// Operation
// (R1) The measurement word carries a 4-bit range exponent in bits 15:12 and a 12-bit mantissa below it.
// (R2) The measurement word is read-only and always holds the outcome of the latest completed conversion.
// (R3) The mantissa is an unsigned binary count from zero to the full scale of the selected range.
// (R4) Exponent codes 0 to 11 select a step of 0.01 lux times two to the exponent, 40.95 to 83865.60 lux.
// (R5) With the exponent mask set and a manual range below 12, the reported exponent field reads zero.
// (R6) A configuration write aborts any running conversion at once.
// (R7) After a configuration write a fresh conversion starts whenever the new settings call for one.
// (R8) The configuration register holds eleven fields, range to fault count, with the four flags read-only.
// (R9) The configuration register resets to c810h.
// (R10) Range code 12 makes the device pick the full-scale range itself and report it as the exponent.
// (R11) Range codes below 12 fix the full-scale range manually with the exponent encoding.
// (R12) The host does not write the reserved range codes 13, 14 or 15.
// (R13) Mode 00 is shutdown, 01 a single conversion, 10 and 11 continuous conversion.
// (R14) Register words cross the serial bus as two bytes, most significant byte first.
// (R15) Host writes into read-only configuration positions are ignored.
package lrr_pkg;

  localparam logic [7:0]  REG_RESULT     = 8'h00;
  localparam logic [7:0]  REG_CONFIG     = 8'h01;
  localparam logic [15:0] CFG_RESET      = 16'hc810;
  localparam logic [3:0]  RANGE_AUTO     = 4'hc;
  localparam logic [3:0]  RANGE_MAX      = 4'hb;
  localparam logic [11:0] MANT_FULL      = 12'hfff;
  localparam logic [1:0]  MODE_SHUTDOWN  = 2'b00;
  localparam logic [1:0]  MODE_SINGLE    = 2'b01;
  localparam logic [6:0]  DEV_ADDR       = 7'h2a;  // Arbitrary target address
  localparam int          RAW_W          = 23;     // Light level in 0.01 lux steps

  // Field positions in the configuration word
  localparam int CFG_RN_LSB   = 12;
  localparam int CFG_CT_BIT   = 11;
  localparam int CFG_MODE_LSB = 9;
  localparam int CFG_LOW_W    = 5;

  // Conversion times
  localparam int CLK_HZ        = 20_000_000;
  localparam int CONV_SHORT_MS = 100;
  localparam int CONV_LONG_MS  = 800;
  localparam int CONV_SHORT_CYC = CONV_SHORT_MS * (CLK_HZ / 1000);
  localparam int CONV_LONG_CYC  = CONV_LONG_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ADRACK = 3'b010,
    ST_RX     = 3'b011,
    ST_RXACK  = 3'b100,
    ST_TX     = 3'b101,
    ST_TXACK  = 3'b110
  } lrr_state_t;

endpackage

// File: tb/lrr_i2c_host.sv
// I2C controller model that reads and writes the 16-bit registers of the sensor.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`default_nettype none

module lrr_i2c_host (
  input  wire logic clk,     // Bench clock
  input  wire logic sdaWire, // Resolved data wire
  output var  logic scl,     // Serial clock drive
  output var  logic sdaLow   // High pulls the data wire low
);
  timeunit 1ns;
  timeprecision 1ps;

  int halfCyc = 10;  // Clock phase length, raised to act as a slow controller

  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data set while the clock is low, sampled at the end of the high phase
  task automatic bitIo(input logic b, output logic r);
    sdaLow <= ~b;
    waitClk(halfCyc);
    scl <= 1'b1;
    waitClk(halfCyc);
    r = sdaWire;
    scl <= 1'b0;
    waitClk(2);
  endtask

  task automatic byteIo(input logic [7:0] tx, input logic ackTx, output logic [7:0] rx,
                        output logic ackRx);
    for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
    bitIo(ackTx, ackRx);
  endtask

  task automatic start();
    sdaLow <= 1'b0;
    waitClk(halfCyc);
    scl <= 1'b1;
    waitClk(halfCyc);
    sdaLow <= 1'b1;
    waitClk(halfCyc);
    scl <= 1'b0;
    waitClk(2);
  endtask

  task automatic stop();
    sdaLow <= 1'b1;
    waitClk(halfCyc);
    scl <= 1'b1;
    waitClk(halfCyc);
    sdaLow <= 1'b0;
    waitClk(halfCyc);
  endtask

  task automatic addrPtr(input logic [7:0] ptr, output logic ok);
    logic [7:0] rx;
    logic       n1;
    logic       n2;
    start();
    byteIo({lrr_pkg::DEV_ADDR, 1'b0}, 1'b1, rx, n1);
    byteIo(ptr, 1'b1, rx, n2);
    ok = ~n1 & ~n2;
  endtask

  task automatic writeWord(input logic [7:0] ptr, input logic [15:0] w, output logic ok);
    logic [7:0] rx;
    logic       a;
    logic       n1;
    logic       n2;
    addrPtr(ptr, a);
    byteIo(w[15:8], 1'b1, rx, n1);
    byteIo(w[7:0], 1'b1, rx, n2);
    stop();
    ok = a & ~n1 & ~n2;
  endtask

  // Master acknowledges the high byte and refuses the low byte to end the read
  task automatic readWord(input logic [7:0] ptr, output logic [15:0] w, output logic ok);
    logic [7:0] rx;
    logic       a;
    logic       n;
    logic       m;
    addrPtr(ptr, a);
    start();
    byteIo({lrr_pkg::DEV_ADDR, 1'b1}, 1'b1, rx, n);
    byteIo(8'hff, 1'b0, w[15:8], m);
    byteIo(8'hff, 1'b1, w[7:0], m);
    stop();
    ok = a & ~n;
  endtask
endmodule

`default_nettype wire

// File: tb/light_result_range_regs_bench.sv
// Self-checking bench for the light result and range registers.
// Assumes the controller model lrr_i2c_host and a pull-up on the serial data line.
`default_nettype none

module light_result_range_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SHORT = 200;
  localparam int LONG  = 2000;
  localparam int LIMIT = 90000;

  logic                      clk;
  logic                      nrst;
  logic                      scl;
  logic                      hostLow;
  logic                      sdaOut;
  logic                      sdaOe;
  logic                      convBusy;
  logic [lrr_pkg::RAW_W-1:0] lightRaw;
  wire                       sdaWire;
  int                        nFail;
  int                        numChecks;
  int                        cycles = 0;

  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~hostLow;

  lrr_light_regs #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut (
    .clk(clk), .nrst(nrst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .lightRaw(lightRaw), .convBusy(convBusy));
  lrr_i2c_host host (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(hostLow));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Checking and bus helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      nFail++;
      $display("ERROR %0t run did not finish in time", $time);
      stop_test();
    end
  end

  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp, input string what);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] w);
    logic ok;
    host.writeWord(p, w, ok);
    chkBit(ok, 1'b1, "write acknowledged");
  endtask

  task automatic rdChk(input logic [7:0] p, input logic [15:0] exp, input string what);
    logic [15:0] w;
    logic        ok;
    host.readWord(p, w, ok);
    chkWord(w, exp, what);
  endtask

  task automatic waitDone(input int limit, output int n);
    n = 0;
    while (convBusy !== 1'b0 && n < limit) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic conv(input logic [15:0] cfg, input logic [22:0] raw);
    int n;
    lightRaw <= raw;
    wr(lrr_pkg::REG_CONFIG, cfg);
    waitDone(SHORT + 50, n);
    chkBit(convBusy, 1'b0, "single conversion ends");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdChk(lrr_pkg::REG_CONFIG, lrr_pkg::CFG_RESET, "config after reset");
    rdChk(lrr_pkg::REG_RESULT, 16'h0000, "result after reset");
    chkBit(convBusy, 1'b0, "idle after reset");
    $display("test reset done");
  endtask

  task automatic t_access();
    logic ok;
    host.halfCyc = 25;
    wr(lrr_pkg::REG_CONFIG, 16'hc1ff);
    rdChk(lrr_pkg::REG_CONFIG, 16'hc01f, "flag bits keep own values");
    host.writeWord(lrr_pkg::REG_RESULT, 16'h1234, ok);
    rdChk(lrr_pkg::REG_RESULT, 16'h0000, "result ignores writes");
    host.halfCyc = 10;
    $display("test access done");
  endtask

  task automatic t_ranges();
    logic [11:0] m;
    for (int e = 0; e <= 11; e++) begin
      m = 12'h456 + 12'(e);
      conv({4'(e), 12'h200}, 23'(m) << e);
      rdChk(lrr_pkg::REG_RESULT, {4'(e), m}, "manual range result");
    end
    rdChk(lrr_pkg::REG_CONFIG, 16'hb080, "single returns to shutdown");
    $display("test ranges done");
  endtask

  task automatic t_mask_auto();
    conv(16'h3204, 23'h456 << 3);
    rdChk(lrr_pkg::REG_RESULT, 16'h0456, "masked exponent");
    conv(16'hc204, 23'h89a << 7);
    rdChk(lrr_pkg::REG_RESULT, 16'h789a, "automatic range");
    conv(16'h0200, 23'h001000);
    rdChk(lrr_pkg::REG_RESULT, 16'h0fff, "manual overflow saturates");
    rdChk(lrr_pkg::REG_CONFIG, 16'h0180, "overflow and ready flags");
    $display("test mask and auto done");
  endtask

  task automatic t_abort();
    int n;
    lightRaw <= 23'h123 << 2;
    wr(lrr_pkg::REG_CONFIG, 16'h1c00);
    chkBit(convBusy, 1'b1, "long continuous conversion runs");
    wr(lrr_pkg::REG_CONFIG, 16'h2200);
    waitDone(LONG, n);
    chkBit(n <= SHORT, 1'b1, "write aborts and restarts timer");
    rdChk(lrr_pkg::REG_RESULT, 16'h2123, "result after restart");
    wr(lrr_pkg::REG_CONFIG, 16'h2400);
    lightRaw <= 23'h321 << 2;
    repeat (2 * SHORT + 20) @(posedge clk);
    rdChk(lrr_pkg::REG_RESULT, 16'h2321, "continuous mode 10");
    wr(lrr_pkg::REG_CONFIG, 16'h2600);
    lightRaw <= 23'h0ab << 2;
    repeat (2 * SHORT + 20) @(posedge clk);
    rdChk(lrr_pkg::REG_RESULT, 16'h20ab, "continuous mode 11");
    wr(lrr_pkg::REG_CONFIG, 16'h2000);
    chkBit(convBusy, 1'b0, "shutdown aborts conversion");
    lightRaw <= 23'h777 << 2;
    repeat (2 * SHORT) @(posedge clk);
    rdChk(lrr_pkg::REG_RESULT, 16'h20ab, "shutdown keeps result");
    $display("test abort done");
  endtask

  initial begin
    nrst = 1'b0;
    lightRaw = '0;
    nFail = 0;
    numChecks = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_access();
    t_ranges();
    t_mask_auto();
    t_abort();
    stop_test();
  end
endmodule

`default_nettype wire
